// >>> design/emac_crc.v
`timescale 1ns/1ns
`include "emac_regs.vh"
module emac_crc (
   // Running checksum and the bytes to fold in, lane 0 first.
   input  wire [31:0] crc_in,
   input  wire [63:0] data,
   input  wire [3:0]  nbytes,
   output reg  [31:0] crc_out
);
   integer i;
   integer b;
   reg     fb;

   // Bit-serial reflected update unrolled over up to eight lanes.
   always @* begin
      crc_out = crc_in;
      fb      = 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
         if (i < nbytes) begin
            for (b = 0; b < 8; b = b + 1) begin
               fb      = crc_out[0] ^ data[8*i+b];
               crc_out = {1'b0, crc_out[31:1]} ^ (fb ? `EMAC_CRC_POLY : 32'h00000000);
            end
         end
      end
   end
endmodule

// >>> design/emac_fifo.v
`timescale 1ns/1ns
module emac_fifo #(
   parameter WIDTH = 70,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   // Clock and reset.
   input  wire             mclk,
   input  wire             resetn,
   // Fill side.
   input  wire             in_valid,
   output reg              in_ready,
   input  wire [WIDTH-1:0] in_data,
   // Drain side.
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wp_r;
   reg [AW-1:0]    rp_r;
   reg [AW:0]      cnt_r;
   reg             nempty_r;
   wire            push = in_valid & in_ready;
   wire            pop  = nempty_r & out_ready;
   wire [AW:0]     cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

   assign out_valid = nempty_r;
   assign out_data  = mem[rp_r];

   // Full and empty are registered so that ready has no combinational path from the drain side.
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wp_r     <= {AW{1'b0}};
         rp_r     <= {AW{1'b0}};
         cnt_r    <= {(AW+1){1'b0}};
         nempty_r <= 1'b0;
         in_ready <= 1'b0;
      end else begin
         if (push) begin
            wp_r <= (wp_r == DEPTH - 1) ? {AW{1'b0}} : wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= (rp_r == DEPTH - 1) ? {AW{1'b0}} : rp_r + 1'b1;
         end
         cnt_r    <= cnt_nxt;
         nempty_r <= (cnt_nxt != 0);
         in_ready <= (cnt_nxt != DEPTH);
      end
   end

   // Storage has no reset; only written words are ever read.
   always @(posedge mclk) begin
      if (push) begin
         mem[wp_r] <= in_data;
      end
   end
endmodule

// >>> design/emac_regs.vh
`ifndef EMAC_REGS_VH
`define EMAC_REGS_VH

// Network side control characters.
`define EMAC_CH_IDLE     8'h07
`define EMAC_CH_TERM     8'hFD
`define EMAC_CH_ERR      8'hFE
`define EMAC_START_COL   64'hD5555555555555FB
`define EMAC_START_CTL   8'h01
`define EMAC_IDLE_COL    64'h0707070707070707
`define EMAC_ERR_COL     64'hFEFEFEFEFEFEFEFE

// Checksum constants.
`define EMAC_CRC_INIT    32'hFFFFFFFF
`define EMAC_CRC_POLY    32'hEDB88320
`define EMAC_CRC_RESIDUE 32'hDEBB20E3

// Register map: address bit 8 selects the sub-block, the low byte the register.
`define EMAC_SEL_BIT     8
`define EMAC_OFF_CTRL    8'h00
`define EMAC_OFF_FRAMES  8'h04
`define EMAC_OFF_ERRS    8'h08
`define EMAC_OFF_OCTETS  8'h0C
`define EMAC_CTRL_RST    2'h3
`define EMAC_CTRL_CRC    0
`define EMAC_CTRL_STATS  1

// Idle columns appended after each transmitted frame.
`define EMAC_IPG_COLS    2'h2

`endif

// >>> design/emac_top.v
`timescale 1ns/1ns
`include "emac_regs.vh"
module emac_top #(
   parameter FIFO_DEPTH = 8,
   parameter FIFO_AW    = 3
) (
   // Clock and reset.
   input  wire        mclk,
   input  wire        resetn,
   // Client transmit sink.
   input  wire [63:0] tx_data,
   input  wire        tx_valid,
   input  wire        tx_sop,
   input  wire        tx_eop,
   input  wire [2:0]  tx_empty,
   input  wire        tx_error,
   output wire        tx_ready,
   // Client receive source.
   output wire [63:0] rx_data,
   output wire        rx_valid,
   output wire        rx_sop,
   output wire        rx_eop,
   output wire [2:0]  rx_empty,
   output wire        rx_error,
   input  wire        rx_ready,
   // Network side.
   output reg  [63:0] xgmii_txd,
   output reg  [7:0]  xgmii_txc,
   input  wire [63:0] xgmii_rxd,
   input  wire [7:0]  xgmii_rxc,
   // Register slave port.
   input  wire [9:0]  csr_address,
   input  wire        csr_read,
   input  wire        csr_write,
   input  wire [31:0] csr_writedata,
   output reg  [31:0] csr_readdata,
   output reg         csr_readdatavalid
);
   localparam T_IDLE = 2'h0;
   localparam T_DATA = 2'h1;
   localparam T_TAIL = 2'h2;
   localparam T_GAP  = 2'h3;
   localparam R_IDLE = 2'h0;
   localparam R_DATA = 2'h1;
   localparam R_LAST = 2'h2;

   // Client words are big endian; lane 0 carries the first byte.
   function [63:0] bswap;
      input [63:0] d;
      integer i;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            bswap[8*i+:8] = d[8*(7-i)+:8];
         end
      end
   endfunction

   // Last data lanes, checksum, terminate and idle fill over two columns.
   function [143:0] tail;
      input [63:0] d;
      input [3:0]  n;
      input [31:0] f;
      input        addf;
      input        err;
      integer i;
      reg [4:0]   e;
      reg [127:0] o;
      reg [15:0]  c;
      begin
         e = {1'b0, n} + (addf ? 5'h04 : 5'h00);
         o = 128'h0;
         c = 16'h0;
         for (i = 0; i < 16; i = i + 1) begin
            if (i < n) begin
               o[8*i+:8] = d[8*(i%8)+:8];
            end else if (i < e) begin
               o[8*i+:8] = f[8*((i-n)%4)+:8];
            end else if (i == e) begin
               o[8*i+:8] = err ? `EMAC_CH_ERR : `EMAC_CH_TERM;
               c[i] = 1'b1;
            end else begin
               o[8*i+:8] = `EMAC_CH_IDLE;
               c[i] = 1'b1;
            end
         end
         tail = {c, o};
      end
   endfunction

   // Lane holding the terminate character, or 8 when there is none.
   function [3:0] term_lane;
      input [63:0] d;
      input [7:0]  c;
      integer i;
      begin
         term_lane = 4'h8;
         for (i = 7; i >= 0; i = i - 1) begin
            if (c[i] && d[8*i+:8] == `EMAC_CH_TERM) begin
               term_lane = i[3:0];
            end
         end
      end
   endfunction

   // Control bits and statistics of both sub-blocks.
   reg  [1:0]  tx_ctrl_r;
   reg  [1:0]  rx_ctrl_r;
   reg  [31:0] tx_frames_r;
   reg  [31:0] tx_errs_r;
   reg  [31:0] tx_octets_r;
   reg  [31:0] rx_frames_r;
   reg  [31:0] rx_errs_r;
   reg  [31:0] rx_octets_r;

   // Transmit path state.
   wire        tf_valid;
   wire [69:0] tf_data;
   reg         tf_pop;
   reg  [1:0]  tx_state_r;
   reg  [31:0] tx_crc_r;
   reg  [63:0] tail_d_r;
   reg  [7:0]  tail_c_r;
   reg  [1:0]  gap_r;
   reg  [31:0] tx_bytes_r;
   wire [63:0] tf_word  = bswap(tf_data[63:0]);
   wire        tf_sop   = tf_data[64];
   wire        tf_eop   = tf_data[65];
   wire [3:0]  tf_n     = 4'h8 - {1'b0, tf_data[68:66]};
   wire        tf_err   = tf_data[69];
   wire [31:0] tx_crc_nxt;
   wire [143:0] tx_tail = tail(tf_word, tf_n, ~tx_crc_nxt, tx_ctrl_r[`EMAC_CTRL_CRC], tf_err);

   emac_fifo #(.WIDTH(70), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_tx_fifo (
      .mclk      (mclk),
      .resetn    (resetn),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .in_data   ({tx_error, tx_empty, tx_eop, tx_sop, tx_data}),
      .out_valid (tf_valid),
      .out_ready (tf_pop),
      .out_data  (tf_data)
   );

   emac_crc u_tx_crc (
      .crc_in  (tx_crc_r),
      .data    (tf_word),
      .nbytes  (tf_eop ? tf_n : 4'h8),
      .crc_out (tx_crc_nxt)
   );

   // The engine pops only in the data state, so the queue holds client words through the start, tail and gap columns.
   always @* begin
      tf_pop = (tx_state_r == T_DATA) && tf_valid;
   end

   // Transmit engine: start column, swapped data, tail with checksum, idle gap.
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tx_state_r  <= T_IDLE;
         xgmii_txd   <= `EMAC_IDLE_COL;
         xgmii_txc   <= 8'hFF;
         tx_crc_r    <= `EMAC_CRC_INIT;
         tail_d_r    <= `EMAC_IDLE_COL;
         tail_c_r    <= 8'hFF;
         gap_r       <= 2'h0;
         tx_bytes_r  <= 32'h0;
         tx_frames_r <= 32'h0;
         tx_errs_r   <= 32'h0;
         tx_octets_r <= 32'h0;
      end else begin
         case (tx_state_r)
            T_IDLE: begin
               xgmii_txd <= `EMAC_IDLE_COL;
               xgmii_txc <= 8'hFF;
               if (tf_valid && tf_sop) begin
                  xgmii_txd  <= `EMAC_START_COL;
                  xgmii_txc  <= `EMAC_START_CTL;
                  tx_crc_r   <= `EMAC_CRC_INIT;
                  tx_bytes_r <= 32'h0;
                  tx_state_r <= T_DATA;
               end
            end
            T_DATA: begin
               if (!tf_valid) begin
                  // A stalled client mid-frame becomes error columns on the wire.
                  xgmii_txd <= `EMAC_ERR_COL;
                  xgmii_txc <= 8'hFF;
               end else if (!tf_eop) begin
                  xgmii_txd  <= tf_word;
                  xgmii_txc  <= 8'h00;
                  tx_crc_r   <= tx_crc_nxt;
                  tx_bytes_r <= tx_bytes_r + 32'h8;
               end else begin
                  xgmii_txd <= tx_tail[63:0];
                  xgmii_txc <= tx_tail[135:128];
                  tail_d_r  <= tx_tail[127:64];
                  tail_c_r  <= tx_tail[143:136];
                  gap_r     <= 2'h0;
                  if (tx_ctrl_r[`EMAC_CTRL_STATS]) begin
                     if (tf_err) begin
                        tx_errs_r <= tx_errs_r + 32'h1;
                     end else begin
                        tx_frames_r <= tx_frames_r + 32'h1;
                        tx_octets_r <= tx_octets_r + tx_bytes_r + {28'h0, tf_n};
                     end
                  end
                  tx_state_r <= T_TAIL;
               end
            end
            T_TAIL: begin
               xgmii_txd  <= tail_d_r;
               xgmii_txc  <= tail_c_r;
               tx_state_r <= T_GAP;
            end
            default: begin
               xgmii_txd <= `EMAC_IDLE_COL;
               xgmii_txc <= 8'hFF;
               gap_r     <= gap_r + 2'h1;
               if (gap_r == `EMAC_IPG_COLS - 2'h1) begin
                  tx_state_r <= T_IDLE;
               end
            end
         endcase
      end
   end

   // Receive path state.
   reg  [1:0]  rx_state_r;
   reg  [31:0] rx_crc_r;
   reg  [63:0] prev_r;
   reg         have_prev_r;
   reg         first_r;
   reg         ovf_r;
   reg  [63:0] last_r;
   reg  [2:0]  last_empty_r;
   reg  [31:0] rx_bytes_r;
   reg         rp_valid_r;
   reg  [69:0] rp_data_r;
   wire        rp_ready;
   wire [69:0] rq_data;
   wire        rp_lost = rp_valid_r & ~rp_ready;
   wire [3:0]  t_lane  = term_lane(xgmii_rxd, xgmii_rxc);
   wire [31:0] rx_crc_nxt;
   wire        crc_ok  = (rx_crc_nxt == `EMAC_CRC_RESIDUE) || !rx_ctrl_r[`EMAC_CTRL_CRC];
   wire        rx_on   = (rx_state_r == R_DATA);

   emac_crc u_rx_crc (
      .crc_in  (rx_crc_r),
      .data    (xgmii_rxd),
      .nbytes  (xgmii_rxc == 8'h00 ? 4'h8 : t_lane),
      .crc_out (rx_crc_nxt)
   );

   emac_fifo #(.WIDTH(70), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_rx_fifo (
      .mclk      (mclk),
      .resetn    (resetn),
      .in_valid  (rp_valid_r),
      .in_ready  (rp_ready),
      .in_data   (rp_data_r),
      .out_valid (rx_valid),
      .out_ready (rx_ready),
      .out_data  (rq_data)
   );

   assign rx_data  = rq_data[63:0];
   assign rx_sop   = rq_data[64];
   assign rx_eop   = rq_data[65];
   assign rx_empty = rq_data[68:66];
   assign rx_error = rq_data[69];

   // Receive engine: check the start column, hold one word back to strip the checksum.
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rx_state_r   <= R_IDLE;
         rx_crc_r     <= `EMAC_CRC_INIT;
         prev_r       <= 64'h0;
         have_prev_r  <= 1'b0;
         first_r      <= 1'b0;
         ovf_r        <= 1'b0;
         last_r       <= 64'h0;
         last_empty_r <= 3'h0;
         rx_bytes_r   <= 32'h0;
         rp_valid_r   <= 1'b0;
         rp_data_r    <= 70'h0;
         rx_frames_r  <= 32'h0;
         rx_errs_r    <= 32'h0;
         rx_octets_r  <= 32'h0;
      end else begin
         // A refused last word is offered again, so every frame keeps its end marker.
         rp_valid_r <= rp_lost & rp_data_r[65];
         // The network cannot be stalled, so a full queue poisons the frame.
         if (rp_lost) begin
            ovf_r <= 1'b1;
         end
         case (rx_state_r)
            R_IDLE: begin
               // A last word still waiting for room costs the next frame as a whole.
               if (xgmii_rxc == `EMAC_START_CTL && xgmii_rxd == `EMAC_START_COL &&
                   !rp_valid_r) begin
                  rx_state_r  <= R_DATA;
                  rx_crc_r    <= `EMAC_CRC_INIT;
                  have_prev_r <= 1'b0;
                  first_r     <= 1'b1;
                  ovf_r       <= 1'b0;
                  rx_bytes_r  <= 32'h0;
               end
            end
            R_DATA: begin
               if (xgmii_rxc == 8'h00) begin
                  rx_crc_r    <= rx_crc_nxt;
                  prev_r      <= bswap(xgmii_rxd);
                  have_prev_r <= 1'b1;
                  if (have_prev_r) begin
                     rp_valid_r <= 1'b1;
                     rp_data_r  <= {1'b0, 3'h0, 1'b0, first_r, prev_r};
                     first_r    <= 1'b0;
                     rx_bytes_r <= rx_bytes_r + 32'h8;
                  end
               end else begin
                  rx_state_r <= R_IDLE;
                  if (have_prev_r) begin
                     rp_valid_r <= 1'b1;
                     if (t_lane == 4'h8) begin
                        rp_data_r <= {1'b1, 3'h0, 1'b1, first_r, prev_r};
                     end else if (t_lane > 4'h4) begin
                        // Data bytes precede the checksum in this column: one more word follows.
                        rp_data_r    <= {1'b0, 3'h0, 1'b0, first_r, prev_r};
                        last_r       <= bswap(xgmii_rxd);
                        last_empty_r <= 3'h4 - t_lane[2:0];
                        rx_bytes_r   <= rx_bytes_r + 32'h8 + {28'h0, t_lane} - 32'h4;
                        rx_state_r   <= R_LAST;
                     end else begin
                        rp_data_r <= {~crc_ok | ovf_r | rp_lost, 3'h4 - t_lane[2:0], 1'b1,
                                      first_r, prev_r};
                        if (rx_ctrl_r[`EMAC_CTRL_STATS]) begin
                           if (crc_ok && !ovf_r && !rp_lost) begin
                              rx_frames_r <= rx_frames_r + 32'h1;
                              rx_octets_r <= rx_octets_r + rx_bytes_r + 32'h4 + {28'h0, t_lane};
                           end else begin
                              rx_errs_r <= rx_errs_r + 32'h1;
                           end
                        end
                     end
                  end
                  if (t_lane > 4'h4) begin
                     ovf_r <= ovf_r | rp_lost | ~crc_ok;
                  end
               end
            end
            R_LAST: begin
               rx_state_r <= R_IDLE;
               rp_valid_r <= 1'b1;
               rp_data_r  <= {ovf_r | rp_lost, last_empty_r, 1'b1, 1'b0, last_r};
               if (rx_ctrl_r[`EMAC_CTRL_STATS]) begin
                  if (!ovf_r && !rp_lost) begin
                     rx_frames_r <= rx_frames_r + 32'h1;
                     rx_octets_r <= rx_octets_r + rx_bytes_r;
                  end else begin
                     rx_errs_r <= rx_errs_r + 32'h1;
                  end
               end
            end
            default: begin
               rx_state_r <= R_IDLE;
            end
         endcase
      end
   end

   // Bridge: address bit 8 picks the sub-block, the low byte picks its register.
   wire        sel_rx = csr_address[`EMAC_SEL_BIT];
   wire [7:0]  off    = csr_address[7:0];
   reg  [31:0] rd_mux;

   always @* begin
      case (off)
         `EMAC_OFF_CTRL:   rd_mux = {30'h0, sel_rx ? rx_ctrl_r : tx_ctrl_r};
         `EMAC_OFF_FRAMES: rd_mux = sel_rx ? rx_frames_r : tx_frames_r;
         `EMAC_OFF_ERRS:   rd_mux = sel_rx ? rx_errs_r : tx_errs_r;
         `EMAC_OFF_OCTETS: rd_mux = sel_rx ? rx_octets_r : tx_octets_r;
         default:          rd_mux = 32'h0;
      endcase
   end

   // Reads answer one cycle later; unmapped offsets read zero, writes to them are dropped.
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tx_ctrl_r         <= `EMAC_CTRL_RST;
         rx_ctrl_r         <= `EMAC_CTRL_RST;
         csr_readdata      <= 32'h0;
         csr_readdatavalid <= 1'b0;
      end else begin
         csr_readdatavalid <= csr_read;
         if (csr_read) begin
            csr_readdata <= rd_mux;
         end
         if (csr_write && off == `EMAC_OFF_CTRL) begin
            if (sel_rx) begin
               rx_ctrl_r <= csr_writedata[1:0];
            end else begin
               tx_ctrl_r <= csr_writedata[1:0];
            end
         end
      end
   end
endmodule

// >>> dv/emac_chk.sv
`timescale 1ns/1ns
`include "emac_regs.vh"
module emac_chk (
   // Clock and reset.
   input wire        mclk,
   input wire        resetn,
   // Client streams.
   input wire        tx_valid,
   input wire        tx_sop,
   input wire        tx_ready,
   input wire [63:0] rx_data,
   input wire        rx_valid,
   input wire        rx_sop,
   input wire        rx_eop,
   input wire [2:0]  rx_empty,
   input wire        rx_error,
   input wire        rx_ready,
   // Network side.
   input wire [63:0] xgmii_txd,
   input wire [7:0]  xgmii_txc,
   input wire [63:0] xgmii_rxd,
   input wire [7:0]  xgmii_rxc,
   // Register port.
   input wire        csr_read,
   input wire        csr_readdatavalid
);
   reg in_pkt_r;

   // Remembers whether the receive source sits between a first and a last word.
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) in_pkt_r <= 1'b0;
      else if (rx_valid && rx_ready) in_pkt_r <= !rx_eop;
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   // Frame starts on either side of the block.
   sequence s_tx_take; tx_valid && tx_ready && tx_sop; endsequence
   sequence s_tx_start; xgmii_txc == 8'h01; endsequence
   sequence s_rx_start;
      xgmii_rxc == 8'h01 && xgmii_rxd == `EMAC_START_COL ##1 xgmii_rxc == 8'h00;
   endsequence

   property p_rd_ans; csr_read |=> csr_readdatavalid; endproperty
   property p_rd_quiet; !csr_read |=> !csr_readdatavalid; endproperty
   property p_rx_hold; rx_valid && !rx_ready |=> rx_valid && $stable(rx_data); endproperty
   property p_rx_ctl;
      rx_valid && !rx_ready |=> $stable({rx_sop, rx_eop, rx_empty, rx_error});
   endproperty
   property p_rx_first; rx_valid && !in_pkt_r |-> rx_sop; endproperty
   property p_rx_mid; rx_valid && in_pkt_r |-> !rx_sop; endproperty
   property p_rx_err; rx_valid && rx_error |-> rx_eop; endproperty
   property p_start_lane;
      s_tx_start |-> xgmii_txd == `EMAC_START_COL ##1 xgmii_txc == 8'h00;
   endproperty
   property p_tx_lat; s_tx_take |-> ##[1:20] s_tx_start; endproperty
   property p_rx_lat; s_rx_start |-> ##[1:16] rx_valid; endproperty

   a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
   a_rd_quiet: assert property (p_rd_quiet) else $error("stray read data");
   a_rx_hold: assert property (p_rx_hold) else $error("rx word dropped");
   a_rx_ctl: assert property (p_rx_ctl) else $error("rx flags changed");
   a_rx_first: assert property (p_rx_first) else $error("rx frame without sop");
   a_rx_mid: assert property (p_rx_mid) else $error("rx sop inside frame");
   a_rx_err: assert property (p_rx_err) else $error("rx error off eop");
   a_start_lane: assert property (p_start_lane) else $error("bad start column");
   a_tx_lat: assert property (p_tx_lat) else $error("tx start late");
   a_rx_lat: assert property (p_rx_lat) else $error("rx word late");
endmodule

bind emac_top emac_chk u_chk (
   .mclk(mclk), .resetn(resetn), .tx_valid(tx_valid), .tx_sop(tx_sop),
   .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_sop(rx_sop),
   .rx_eop(rx_eop), .rx_empty(rx_empty), .rx_error(rx_error), .rx_ready(rx_ready),
   .xgmii_txd(xgmii_txd), .xgmii_txc(xgmii_txc), .xgmii_rxd(xgmii_rxd),
   .xgmii_rxc(xgmii_rxc), .csr_read(csr_read), .csr_readdatavalid(csr_readdatavalid)
);

// >>> dv/emac_phy_model.sv
`timescale 1ns/1ns
module emac_phy_model (
   // Clock and reset.
   input  wire        mclk,
   input  wire        resetn,
   // Bench controls.
   input  wire        slow,
   input  wire        corrupt,
   // Network columns.
   input  wire [63:0] txd,
   input  wire [7:0]  txc,
   output wire [63:0] rxd,
   output wire [7:0]  rxc
);
   reg [63:0] d1_r;
   reg [63:0] d2_r;
   reg [7:0]  c1_r;
   reg [7:0]  c2_r;

   // Line loopback; corrupt flips one bit of data columns so the checksum fails.
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         d1_r <= 64'h0707070707070707;
         d2_r <= 64'h0707070707070707;
         c1_r <= 8'hFF;
         c2_r <= 8'hFF;
      end else begin
         d1_r <= txd ^ ((corrupt && txc == 8'h00) ? 64'h100 : 64'h0);
         c1_r <= txc;
         d2_r <= d1_r;
         c2_r <= c1_r;
      end
   end

   // Slow mode adds one column of line delay; only switched between frames.
   assign rxd = slow ? d2_r : d1_r;
   assign rxc = slow ? c2_r : c1_r;
endmodule

// >>> dv/ten_gig_mac_top_interfaces_tb.sv
`timescale 1ns/1ns
module ten_gig_mac_top_interfaces_tb;
   reg         mclk = 1'b0;
   reg         resetn = 1'b0;
   reg  [63:0] tx_data = 64'h0;
   reg         tx_valid = 1'b0;
   reg         tx_sop = 1'b0;
   reg         tx_eop = 1'b0;
   reg  [2:0]  tx_empty = 3'h0;
   reg         tx_error = 1'b0;
   reg         rx_ready = 1'b1;
   reg  [9:0]  csr_address = 10'h000;
   reg         csr_read = 1'b0;
   reg         csr_write = 1'b0;
   reg  [31:0] csr_writedata = 32'h0;
   reg         slow = 1'b0;
   reg         corrupt = 1'b0;
   wire        tx_ready, rx_valid, rx_sop, rx_eop, rx_error, csr_readdatavalid;
   wire [63:0] rx_data, xgmii_txd, xgmii_rxd;
   wire [2:0]  rx_empty;
   wire [7:0]  xgmii_txc, xgmii_rxc;
   wire [31:0] csr_readdata;
   integer     failures = 0;
   integer     check_count = 0;
   reg  [63:0] rq_d[$];
   reg  [5:0]  rq_f[$];
   reg  [63:0] col_q[$];
   reg  [7:0]  last_txc = 8'hFF;

   // Free-running clock.
   always #5 mclk = ~mclk;

   emac_top uut (
      .mclk(mclk), .resetn(resetn), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_sop(tx_sop), .tx_eop(tx_eop), .tx_empty(tx_empty), .tx_error(tx_error),
      .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_sop(rx_sop),
      .rx_eop(rx_eop), .rx_empty(rx_empty), .rx_error(rx_error), .rx_ready(rx_ready),
      .xgmii_txd(xgmii_txd), .xgmii_txc(xgmii_txc), .xgmii_rxd(xgmii_rxd),
      .xgmii_rxc(xgmii_rxc), .csr_address(csr_address), .csr_read(csr_read),
      .csr_write(csr_write), .csr_writedata(csr_writedata), .csr_readdata(csr_readdata),
      .csr_readdatavalid(csr_readdatavalid)
   );

   emac_phy_model u_phy (
      .mclk(mclk), .resetn(resetn), .slow(slow), .corrupt(corrupt),
      .txd(xgmii_txd), .txc(xgmii_txc), .rxd(xgmii_rxd), .rxc(xgmii_rxc)
   );

   // Sampled at the falling edge, where every flop output has settled.
   always @(negedge mclk) begin
      if (rx_valid && rx_ready) begin
         rq_d.push_back(rx_data);
         rq_f.push_back({rx_sop, rx_eop, rx_empty, rx_error});
      end
      if (last_txc == 8'h01 && xgmii_txc == 8'h00) col_q.push_back(xgmii_txd);
      last_txc = xgmii_txc;
   end

   task chk(input [63:0] got, input [63:0] exp);
   begin
      check_count = check_count + 1;
      if (got !== exp) begin
         failures = failures + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask

   task wrap_up;
   begin
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   end
   endtask

   task rd(input [9:0] a, input [31:0] exp);
   begin
      @(posedge mclk);
      csr_read <= 1'b1;
      csr_address <= a;
      @(posedge mclk);
      csr_read <= 1'b0;
      @(negedge mclk);
      chk(csr_readdatavalid, 1'b1);
      chk(csr_readdata, exp);
   end
   endtask

   task wr(input [9:0] a, input [31:0] v);
   begin
      @(posedge mclk);
      csr_write <= 1'b1;
      csr_address <= a;
      csr_writedata <= v;
      @(posedge mclk);
      csr_write <= 1'b0;
   end
   endtask

   // A frame goes out word by word with no gaps; a word moves when ready is high.
   task send(input integer n, input [31:0] base, input [2:0] emp);
      integer i;
   begin
      for (i = 0; i < n; i = i + 1) begin
         @(posedge mclk);
         tx_valid <= 1'b1;
         tx_data  <= {base, i[31:0]};
         tx_sop   <= (i == 0);
         tx_eop   <= (i == n - 1);
         tx_empty <= (i == n - 1) ? emp : 3'h0;
         @(negedge mclk);
         while (!tx_ready) @(negedge mclk);
      end
      @(posedge mclk);
      tx_valid <= 1'b0;
   end
   endtask

   task expect_rx(input integer n, input [31:0] base, input [2:0] emp);
      integer    i;
      integer    sh;
      reg [5:0]  f;
      reg [63:0] d;
   begin
      i = 0;
      while (rq_d.size() < n && i < 300) begin
         @(posedge mclk);
         i = i + 1;
      end
      chk(rq_d.size() >= n, 1'b1);
      for (i = 0; i < n && rq_d.size() > 0; i = i + 1) begin
         f = rq_f.pop_front();
         d  = rq_d.pop_front();
         // Lanes that empty marks unused carry no data and are left out.
         sh = (i == n - 1) ? 8 * emp : 0;
         chk(d >> sh, {base, i[31:0]} >> sh);
         chk({f[5:4], f[0]}, {i == 0, i == n - 1, 1'b0});
         if (i == n - 1) chk(f[3:1], emp);
      end
   end
   endtask

   task t_regs;
   begin
      rd(10'h000, 32'h3);
      rd(10'h100, 32'h3);
      rd(10'h104, 32'h0);
      rd(10'h010, 32'h0);
      wr(10'h004, 32'h55);
      rd(10'h004, 32'h0);
      $display("register test done");
   end
   endtask

   task t_loop(input s, input [31:0] cnt);
   begin
      @(posedge mclk);
      slow <= s;
      send(3, 32'h01234567, 3'h2);
      expect_rx(3, 32'h01234567, 3'h2);
      chk(col_q.pop_front(), 64'h0000000067452301);
      rd(10'h004, cnt);
      rd(10'h104, cnt);
      rd(10'h00C, 32'h16 * cnt);
      rd(10'h10C, 32'h16 * cnt);
      $display("loopback test done");
   end
   endtask

   task t_back;
   begin
      @(posedge mclk);
      rx_ready <= 1'b0;
      send(2, 32'hCAFE0001, 3'h0);
      send(3, 32'hCAFE0002, 3'h7);
      repeat (20) @(posedge mclk);
      rx_ready <= 1'b1;
      expect_rx(2, 32'hCAFE0001, 3'h0);
      expect_rx(3, 32'hCAFE0002, 3'h7);
      $display("backpressure test done");
   end
   endtask

   task t_bad;
      reg [5:0] f;
   begin
      @(posedge mclk);
      corrupt <= 1'b1;
      send(2, 32'h0000BEEF, 3'h4);
      repeat (40) @(posedge mclk);
      corrupt <= 1'b0;
      chk(rq_d.size(), 2);
      f = rq_f.pop_back();
      chk({f[4], f[0]}, 2'h3);
      rq_d.delete();
      rq_f.delete();
      rd(10'h108, 32'h1);
      $display("checksum error test done");
   end
   endtask

   task t_over;
      reg [5:0] f;
   begin
      @(posedge mclk);
      rx_ready <= 1'b0;
      send(12, 32'h0BAD0000, 3'h0);
      repeat (20) @(posedge mclk);
      rx_ready <= 1'b1;
      repeat (20) @(posedge mclk);
      chk(rq_d.size() >= 1 && rq_d.size() <= 9, 1'b1);
      while (rq_f.size() > 1) f = rq_f.pop_front();
      f = rq_f.pop_front();
      chk({f[4], f[0]}, 2'h3);
      rq_d.delete();
      $display("overflow test done");
   end
   endtask

   // Main sequence: reset for two cycles, then two idle cycles before any access.
   initial begin
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      repeat (2) @(posedge mclk);
      t_regs;
      t_loop(1'b0, 32'h1);
      t_loop(1'b1, 32'h2);
      t_back;
      t_bad;
      t_over;
      wrap_up;
   end

   // The tests need a few hundred cycles; this cuts a hang short.
   initial begin
      #50000;
      failures = failures + 1;
      wrap_up;
   end
endmodule
